/* File: lsi_pkg.sv */
// Constants and carrier types of the line sense and status block
package lsi_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_EVENTS    = 6'h03;
  localparam logic [5:0] IDX_IRQ_EN    = 6'h05;
  localparam logic [5:0] IDX_RING_THR  = 6'h0E;
  localparam logic [5:0] IDX_FAULT_EN  = 6'h12;
  localparam logic [5:0] IDX_OV_THR    = 6'h13;
  localparam logic [5:0] IDX_RX_BOOST  = 6'h14;
  localparam logic [5:0] IDX_SENSE_EN  = 6'h15;
  localparam logic [5:0] IDX_RING_RES  = 6'h1A;
  localparam logic [5:0] IDX_LINE_RES  = 6'h1B;
  localparam logic [5:0] IDX_LOOP_RES  = 6'h1C;
  localparam logic [5:0] IDX_LIVE_STAT = 6'h1E;
  localparam logic [5:0] IDX_LINE_CFG  = 6'h20;

  // Field positions
  localparam int BIT_RING_EVT   = 0;
  localparam int BIT_FAULT_EVT  = 2;
  localparam int BIT_RING_MON   = 3;
  localparam int BIT_RING_IE    = 0;
  localparam int BIT_FAULT_IE   = 2;
  localparam int BIT_MASTER_EN  = 1;
  localparam int BIT_OV_THR     = 2;
  localparam int BIT_BOOST      = 3;
  localparam int BIT_OC_EN      = 0;
  localparam int BIT_OV_EN      = 1;
  localparam int BIT_UV_EN      = 2;
  localparam int BIT_CID        = 4;
  localparam int BIT_OL_EN      = 7;
  localparam int BIT_UV_STAT    = 6;
  localparam int BIT_OV_STAT    = 5;
  localparam int BIT_OC_STAT    = 4;
  localparam int BIT_OL_STAT    = 3;
  localparam int BIT_FEED       = 0;
  localparam int BIT_NOMINAL    = 1;
  localparam int BIT_ILIM       = 2;

  // Reset values
  localparam logic RST_RING_IE  = 1'h1;
  localparam logic RST_FAULT_IE = 1'h0;

  // Thresholds in converter counts (about 10.23 mV or 1.25 mA a count)
  localparam logic [6:0] RING_THR_1  = 7'h0F; // 0.15 Vpk
  localparam logic [6:0] RING_THR_2  = 7'h1D; // 0.30 Vpk
  localparam logic [6:0] RING_THR_3  = 7'h2C; // 0.45 Vpk
  localparam logic [6:0] OV_THR_LO   = 7'h3B; // 0.6 Vpk
  localparam logic [6:0] OV_THR_HI   = 7'h44; // 0.7 Vpk
  localparam logic [6:0] OC_THR_HI   = 7'h64; // 125 mA
  localparam logic [6:0] OC_THR_LO   = 7'h2C; // 55 mA
  localparam logic [7:0] OL_DELTA    = 8'h4C; // 76 counts
  localparam logic [7:0] GAIN_20DB   = 8'h0A; // x10 in amplitude
  localparam logic [7:0] GAIN_UNITY  = 8'h01;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One auxiliary converter result set from the line front end
  typedef struct packed {
    logic       sampleValid;
    logic [7:0] ringCode;   // ones' complement
    logic [7:0] lineCode;
    logic [6:0] loopCode;
  } lsi_aux_s;

endpackage

/* File: lsi_line_sense.sv */
// Line sensing control, status capture and interrupt logic
//
// Behaviour
// - Caller-ID routes ring audio, +20 dB, to transmit
// - Receive boost adds 20 dB, resets off
// - Ring interrupt enable, resets to one
// - Ring above threshold latches flag, read clears
// - Ringing monitor live, read also resets it
// - Threshold code 0 disables, else 0.15/0.30/0.45
// - Loop current magnitude in bits 7:1
// - Line voltage top seven bits in 7:1
// - Ring voltage ones' complement byte reported
// - Fault flag on UV/OV/OC, read clears
// - Fault interrupt enable, resets to zero
// - Master enable gates UV, OV, OC
// - Under-voltage forces wide loop bandwidth
// - Live under- and over-voltage status bits
// - Over-voltage needs own, feed, nominal enables
// - Over-voltage threshold 0.6 or 0.7 Vpk
// - Overload when sample delta exceeds 76
// - Overload enable, condition not latched
// - Over-current above 125 mA or 55 mA
// - Over-current enable, resets to zero
// - Over-current or over-voltage forces on-hook
// - Under-voltage in line power switches to barrier
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
module lsi_line_sense #(
  parameter int ADDR_W = 8,
  parameter int PCM_W  = 16
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Line front end
  input  wire lsi_pkg::lsi_aux_s      auxIn,
  input  wire logic                   supplyUnderVoltage,
  input  wire logic                   linePoweredMode,
  input  wire logic                   audioValid,
  input  wire logic signed [PCM_W-1:0] rxAudio,
  input  wire logic signed [PCM_W-1:0] ringAudio,
  // Outputs
  output logic signed [PCM_W-1:0]     pcmTransmitOut,
  output logic                        pcmTransmitValid,
  output logic                        irq,
  output logic                        onHookRequest,
  output logic                        wideBandwidthForce,
  output logic                        barrierPowerSwitch
);

  // Control registers
  logic       ringIrqEn_q, faultIrqEn_q, masterEn_q, ovThrSel_q, boost_q;
  logic       ocEn_q, ovEn_q, uvEn_q, cidEn_q, olEn_q;
  logic       feedEn_q, nominalEn_q, ilimSel_q;
  logic [1:0] ringThr_q;
  // Captured converter results and status
  logic [7:0] ringCode_q, lineCode_q, prevLine_q;
  logic [6:0] loopCode_q;
  logic       havePrev_q, newSample_q;
  logic       uvStat_q, ovStat_q, ocStat_q, olStat_q;
  logic       ringFlag_q, faultFlag_q, ringMon_q;
  // Bus state
  logic              awHave_q, wHave_q;
  logic [5:0]        wIdx_q;
  logic [7:0]        wByte_q;
  logic              wLane_q;

  logic [5:0]  rIdx;
  logic        rdTake, rdClear, doWrite;
  logic [7:0]  rByte;
  logic        rMapped, wMapped;
  logic [6:0]  ringMag, ringThrCnt, ovThrCnt, ocThrCnt;
  logic [7:0]  lineDelta;
  logic        ringAbove;

  assign rIdx    = s_axi_araddr[7:2];
  assign rdTake  = s_axi_arvalid & s_axi_arready;
  assign rdClear = rdTake & (rIdx == lsi_pkg::IDX_EVENTS);
  assign doWrite = awHave_q & wHave_q & ~s_axi_bvalid;

  // Magnitude of the ones' complement ring code
  assign ringMag = ringCode_q[7] ? ~ringCode_q[6:0] : ringCode_q[6:0];

  // Threshold selection
  always_comb begin
    case (ringThr_q)
      2'h1:    ringThrCnt = lsi_pkg::RING_THR_1;
      2'h2:    ringThrCnt = lsi_pkg::RING_THR_2;
      default: ringThrCnt = lsi_pkg::RING_THR_3;
    endcase
    ovThrCnt = ovThrSel_q ? lsi_pkg::OV_THR_HI : lsi_pkg::OV_THR_LO;
    ocThrCnt = ilimSel_q ? lsi_pkg::OC_THR_LO : lsi_pkg::OC_THR_HI;
    lineDelta = (lineCode_q > prevLine_q) ? lineCode_q - prevLine_q
                                          : prevLine_q - lineCode_q;
    ringAbove = (ringThr_q != 2'h0) && (ringMag > ringThrCnt);
  end

  // Converter result capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ringCode_q  <= 8'h00;
      lineCode_q  <= 8'h00;
      prevLine_q  <= 8'h00;
      loopCode_q  <= 7'h00;
      havePrev_q  <= 1'b0;
      newSample_q <= 1'b0;
    end else begin
      newSample_q <= auxIn.sampleValid;
      if (auxIn.sampleValid) begin
        ringCode_q <= auxIn.ringCode;
        lineCode_q <= auxIn.lineCode;
        prevLine_q <= havePrev_q ? lineCode_q : auxIn.lineCode;
        loopCode_q <= auxIn.loopCode;
        havePrev_q <= 1'b1;
      end
    end
  end

  // Live detector status, gated by the enables
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      uvStat_q <= 1'b0;
      ovStat_q <= 1'b0;
      ocStat_q <= 1'b0;
      olStat_q <= 1'b0;
    end else begin
      uvStat_q <= masterEn_q & uvEn_q & supplyUnderVoltage;
      ovStat_q <= masterEn_q & ovEn_q & feedEn_q & nominalEn_q
                  & (ringMag > ovThrCnt);
      ocStat_q <= masterEn_q & ocEn_q & (loopCode_q > ocThrCnt);
      olStat_q <= olEn_q & havePrev_q
                  & (lineDelta > lsi_pkg::OL_DELTA);
    end
  end

  // Sticky event flags; a new event wins over the read clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ringFlag_q  <= 1'b0;
      faultFlag_q <= 1'b0;
      ringMon_q   <= 1'b0;
    end else begin
      if (newSample_q & ringAbove)
        ringFlag_q <= 1'b1;
      else if (rdClear)
        ringFlag_q <= 1'b0;
      if (uvStat_q | ovStat_q | ocStat_q)
        faultFlag_q <= 1'b1;
      else if (rdClear)
        faultFlag_q <= 1'b0;
      if (ringAbove)
        ringMon_q <= 1'b1;
      else if (rdClear | newSample_q)
        ringMon_q <= 1'b0;
    end
  end

  // Line-side protective actions
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      onHookRequest      <= 1'b0;
      wideBandwidthForce <= 1'b0;
      barrierPowerSwitch <= 1'b0;
      irq                <= 1'b0;
    end else begin
      onHookRequest      <= ovStat_q | ocStat_q;
      wideBandwidthForce <= uvStat_q;
      barrierPowerSwitch <= uvStat_q & linePoweredMode;
      irq <= (ringFlag_q & ringIrqEn_q)
             | (faultFlag_q & faultIrqEn_q);
    end
  end

  // Transmit audio path with caller-ID routing and boost
  logic signed [PCM_W-1:0]   audioSrc;
  logic signed [PCM_W+15:0]  audioProd;
  logic signed [PCM_W-1:0]   audioSat;
  logic        [7:0]         gainA, gainB;
  localparam logic signed [PCM_W+15:0] SAT_HI = (1 <<< (PCM_W - 1)) - 1;
  localparam logic signed [PCM_W+15:0] SAT_LO = -(1 <<< (PCM_W - 1));

  always_comb begin
    audioSrc  = cidEn_q ? ringAudio : rxAudio;
    gainA     = cidEn_q ? lsi_pkg::GAIN_20DB : lsi_pkg::GAIN_UNITY;
    gainB     = boost_q ? lsi_pkg::GAIN_20DB : lsi_pkg::GAIN_UNITY;
    // Widened before multiplying so a loud sample saturates, not wraps
    audioProd = (PCM_W+16)'(audioSrc)
                * (PCM_W+16)'($signed({1'b0, gainA}))
                * (PCM_W+16)'($signed({1'b0, gainB}));
    if (audioProd > SAT_HI)
      audioSat = SAT_HI[PCM_W-1:0];
    else if (audioProd < SAT_LO)
      audioSat = SAT_LO[PCM_W-1:0];
    else
      audioSat = audioProd[PCM_W-1:0];
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pcmTransmitOut   <= '0;
      pcmTransmitValid <= 1'b0;
    end else begin
      pcmTransmitValid <= audioValid;
      if (audioValid)
        pcmTransmitOut <= audioSat;
    end
  end

  // Write channel capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      wIdx_q        <= 6'h00;
      wByte_q       <= 8'h00;
      wLane_q       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lsi_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHave_q      <= 1'b1;
        wIdx_q        <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHave_q      <= 1'b1;
        wByte_q      <= s_axi_wdata[7:0];
        wLane_q      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wMapped ? lsi_pkg::RESP_OKAY
                                : lsi_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Writable map
  always_comb begin
    if (wIdx_q == lsi_pkg::IDX_IRQ_EN)
      wMapped = 1'b1;
    else if (wIdx_q == lsi_pkg::IDX_RING_THR)
      wMapped = 1'b1;
    else if (wIdx_q == lsi_pkg::IDX_FAULT_EN)
      wMapped = 1'b1;
    else if (wIdx_q == lsi_pkg::IDX_OV_THR)
      wMapped = 1'b1;
    else if (wIdx_q == lsi_pkg::IDX_RX_BOOST)
      wMapped = 1'b1;
    else if (wIdx_q == lsi_pkg::IDX_SENSE_EN)
      wMapped = 1'b1;
    else if (wIdx_q == lsi_pkg::IDX_LINE_CFG)
      wMapped = 1'b1;
    else
      wMapped = 1'b0;
  end

  // Control register writes; byte lane 0 carries every field
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ringIrqEn_q  <= lsi_pkg::RST_RING_IE;
      faultIrqEn_q <= lsi_pkg::RST_FAULT_IE;
      ringThr_q    <= 2'h0;
      masterEn_q   <= 1'b0;
      ovThrSel_q   <= 1'b0;
      boost_q      <= 1'b0;
      ocEn_q       <= 1'b0;
      ovEn_q       <= 1'b0;
      uvEn_q       <= 1'b0;
      cidEn_q      <= 1'b0;
      olEn_q       <= 1'b0;
      feedEn_q     <= 1'b0;
      nominalEn_q  <= 1'b0;
      ilimSel_q    <= 1'b0;
    end else if (doWrite & wLane_q) begin
      if (wIdx_q == lsi_pkg::IDX_IRQ_EN) begin
        ringIrqEn_q  <= wByte_q[lsi_pkg::BIT_RING_IE];
        faultIrqEn_q <= wByte_q[lsi_pkg::BIT_FAULT_IE];
      end else if (wIdx_q == lsi_pkg::IDX_RING_THR) begin
        ringThr_q <= wByte_q[1:0];
      end else if (wIdx_q == lsi_pkg::IDX_FAULT_EN) begin
        masterEn_q <= wByte_q[lsi_pkg::BIT_MASTER_EN];
      end else if (wIdx_q == lsi_pkg::IDX_OV_THR) begin
        ovThrSel_q <= wByte_q[lsi_pkg::BIT_OV_THR];
      end else if (wIdx_q == lsi_pkg::IDX_RX_BOOST) begin
        boost_q <= wByte_q[lsi_pkg::BIT_BOOST];
      end else if (wIdx_q == lsi_pkg::IDX_SENSE_EN) begin
        ocEn_q  <= wByte_q[lsi_pkg::BIT_OC_EN];
        ovEn_q  <= wByte_q[lsi_pkg::BIT_OV_EN];
        uvEn_q  <= wByte_q[lsi_pkg::BIT_UV_EN];
        cidEn_q <= wByte_q[lsi_pkg::BIT_CID];
        olEn_q  <= wByte_q[lsi_pkg::BIT_OL_EN];
      end else if (wIdx_q == lsi_pkg::IDX_LINE_CFG) begin
        feedEn_q    <= wByte_q[lsi_pkg::BIT_FEED];
        nominalEn_q <= wByte_q[lsi_pkg::BIT_NOMINAL];
        ilimSel_q   <= wByte_q[lsi_pkg::BIT_ILIM];
      end
    end
  end

  // Read decode; write-only registers read as zero
  always_comb begin
    rByte   = 8'h00;
    rMapped = 1'b1;
    if (rIdx == lsi_pkg::IDX_EVENTS) begin
      rByte[lsi_pkg::BIT_RING_EVT]  = ringFlag_q;
      rByte[lsi_pkg::BIT_FAULT_EVT] = faultFlag_q;
      rByte[lsi_pkg::BIT_RING_MON]  = ringMon_q;
    end else if (rIdx == lsi_pkg::IDX_IRQ_EN) begin
      rByte[lsi_pkg::BIT_RING_IE]  = ringIrqEn_q;
      rByte[lsi_pkg::BIT_FAULT_IE] = faultIrqEn_q;
    end else if (rIdx == lsi_pkg::IDX_RING_THR) begin
      rByte[1:0] = ringThr_q;
    end else if (rIdx == lsi_pkg::IDX_FAULT_EN
                 || rIdx == lsi_pkg::IDX_OV_THR
                 || rIdx == lsi_pkg::IDX_RX_BOOST) begin
      rByte = 8'h00;
    end else if (rIdx == lsi_pkg::IDX_SENSE_EN) begin
      rByte[lsi_pkg::BIT_CID] = cidEn_q;
    end else if (rIdx == lsi_pkg::IDX_RING_RES) begin
      rByte = ringCode_q;
    end else if (rIdx == lsi_pkg::IDX_LINE_RES) begin
      rByte = {lineCode_q[7:1], 1'b0};
    end else if (rIdx == lsi_pkg::IDX_LOOP_RES) begin
      rByte = {loopCode_q, 1'b0};
    end else if (rIdx == lsi_pkg::IDX_LIVE_STAT) begin
      rByte[lsi_pkg::BIT_UV_STAT] = uvStat_q;
      rByte[lsi_pkg::BIT_OV_STAT] = ovStat_q;
      rByte[lsi_pkg::BIT_OC_STAT] = ocStat_q;
      rByte[lsi_pkg::BIT_OL_STAT] = olStat_q;
    end else if (rIdx == lsi_pkg::IDX_LINE_CFG) begin
      rByte[lsi_pkg::BIT_FEED]    = feedEn_q;
      rByte[lsi_pkg::BIT_NOMINAL] = nominalEn_q;
      rByte[lsi_pkg::BIT_ILIM]    = ilimSel_q;
    end else begin
      rMapped = 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= lsi_pkg::RESP_OKAY;
    end else if (rdTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rByte};
      s_axi_rresp   <= rMapped ? lsi_pkg::RESP_OKAY
                               : lsi_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* File: lsi_checker.sv */
// Port assertions of the line sense and status block
`timescale 1ns/1ns
module lsi_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        supplyUnderVoltage,
  input wire logic        linePoweredMode,
  input wire logic        audioValid,
  input wire logic        pcmTransmitValid,
  input wire logic        irq,
  input wire logic        wideBandwidthForce,
  input wire logic        barrierPowerSwitch
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Register bus answers and holds
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("late read answer");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("resp dropped");
  AST_WR_AFTER_BOTH: assert property ($rose(s_axi_bvalid)
    |-> !s_axi_awready && !s_axi_wready) else $error("early response");
  AST_RD_UPPER: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");

  // Audio, line protection and interrupt relations
  AST_PCM_PULSE: assert property (
    pcmTransmitValid == $past(audioValid)) else $error("audio valid off");
  AST_WIDE_CAUSE: assert property (wideBandwidthForce
    |-> $past(supplyUnderVoltage, 2)) else $error("wide without cause");
  AST_BARRIER: assert property (barrierPowerSwitch |->
    wideBandwidthForce && ($past(linePoweredMode)
    || $past(linePoweredMode, 2))) else $error("barrier without cause");
  AST_IRQ_FALL: assert property ($fell(irq)
    |-> $past(s_axi_rvalid) || $past(s_axi_bvalid))
    else $error("irq fell without access");
endmodule

bind lsi_line_sense lsi_checker lsi_checker_inst (
  .ref_clk, .rst_n, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .supplyUnderVoltage,
  .linePoweredMode, .audioValid, .pcmTransmitValid, .irq,
  .wideBandwidthForce, .barrierPowerSwitch
);

/* File: lsi_line_model.sv */
// Line front end model: auxiliary converter samples toward the block
`timescale 1ns/1ns
module lsi_line_model (
  input  wire logic         ref_clk,
  output lsi_pkg::lsi_aux_s auxIn
);
  initial auxIn = '0;

  // One sample pulse; afterwards the data lines no longer hold the word
  task automatic put(input logic [7:0] r, input logic [7:0] l,
                     input logic [6:0] c, input int gap);
    auxIn <= {1'b1, r, l, c};
    @(posedge ref_clk);
    auxIn <= {1'b0, ~r, ~l, ~c};
    repeat (gap) @(posedge ref_clk);
  endtask
endmodule

/* File: lsi_testbench.sv */
// Self-checking testbench of the line sense and status block
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [5:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] br;
    logic [1:0] rr;
  } lsi_tb_row_s;
  localparam logic [1:0] OK = lsi_pkg::RESP_OKAY;
  localparam logic [1:0] ER = lsi_pkg::RESP_SLVERR;
  logic                ref_clk, rst_n, s_axi_awvalid, s_axi_awready;
  logic                s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready, supplyUnderVoltage;
  logic                linePoweredMode, audioValid, pcmTransmitValid;
  logic                irq, onHookRequest, wideBandwidthForce;
  logic                barrierPowerSwitch;
  logic [7:0]          s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic signed [15:0]  rxAudio, ringAudio, pcmTransmitOut;
  wire lsi_pkg::lsi_aux_s auxIn;
  int                  miscompares = 0;
  int                  n_checks = 0;
  int                  k;
  logic [6:0]          rthr [4] = '{7'h7E, lsi_pkg::RING_THR_1,
                                    lsi_pkg::RING_THR_2, lsi_pkg::RING_THR_3};
  logic [6:0]          othr [2] = '{lsi_pkg::OC_THR_HI, lsi_pkg::OC_THR_LO};
  logic [6:0]          vthr [2] = '{lsi_pkg::OV_THR_LO, lsi_pkg::OV_THR_HI};
  logic [31:0]         gain [4] = '{32'h64, 32'h46, 32'h3E8, 32'h2BC};
  // Register rows: index, write data, read-back, write and read codes
  lsi_tb_row_s         rows [9] = '{
    '{6'h05, 8'h05, 8'h05, OK, OK}, '{6'h0E, 8'h02, 8'h02, OK, OK},
    '{6'h12, 8'h02, 8'h00, OK, OK}, '{6'h13, 8'h04, 8'h00, OK, OK},
    '{6'h14, 8'h08, 8'h00, OK, OK}, '{6'h15, 8'h10, 8'h10, OK, OK},
    '{6'h1E, 8'hFF, 8'h00, ER, OK}, '{6'h03, 8'hFF, 8'h00, ER, OK},
    '{6'h3F, 8'h11, 8'h00, ER, ER}};

  lsi_line_sense #(.ADDR_W(8), .PCM_W(16)) lsi_line_sense_inst (
    .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .auxIn, .supplyUnderVoltage,
    .linePoweredMode, .audioValid, .rxAudio, .ringAudio, .pcmTransmitOut,
    .pcmTransmitValid, .irq, .onHookRequest, .wideBandwidthForce,
    .barrierPowerSwitch);
  lsi_line_model lsi_line_model_inst (.ref_clk, .auxIn);

  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic sm(input logic [7:0] r, input logic [7:0] l,
                    input logic [6:0] c);
    lsi_line_model_inst.put(r, l, c, 5);
  endtask
  // Register write: waits for the response, then checks its code
  task automatic wr(input logic [5:0] i, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
    @(posedge ref_clk);
  endtask
  // Register read: waits for the answer, checks code and data
  task automatic rd(input logic [5:0] i, input logic [7:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= {i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    chk({s_axi_rvalid, s_axi_rresp}, {1'b1, er});
    chk(s_axi_rdata, {24'h0, e});
    @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, audioValid, supplyUnderVoltage, linePoweredMode} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rxAudio, ringAudio} = '0;
    s_axi_wstrb = 4'hF;
    rst_n = 1'b0;
    tk(16);
    rst_n <= 1'b1;
    tk(1);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd, rows[i].br);
      rd(rows[i].idx, rows[i].rd, rows[i].rr);
    end
    rst_n <= 1'b0;
    tk(16);
    rst_n <= 1'b1;
    tk(1);
    rd(6'h05, 8'h01, OK);
    rd(6'h15, 8'h00, OK);
    // Masked ring event still latches
    wr(6'h05, 8'h00, OK);
    wr(6'h0E, 8'h01, OK);
    sm(8'h7F, 8'h00, 7'h00);
    chk(32'(irq), 32'h0);
    rd(6'h03, 8'h09, OK);
    wr(6'h05, 8'h01, OK);
    // Every threshold code at its limit and one count above
    for (k = 3; k >= 0; k--) begin
      wr(6'h0E, 8'(k), OK);
      sm({1'b0, rthr[k]}, 8'h00, 7'h00);
      rd(6'h03, 8'h00, OK);
      sm({1'b1, ~(rthr[k] + 7'h01)}, 8'h00, 7'h00);
      chk(32'(irq), 32'(k != 0));
      rd(6'h03, (k != 0) ? 8'h09 : 8'h00, OK);
      sm(8'h00, 8'h00, 7'h00);
      rd(6'h03, 8'h00, OK);
      chk(32'(irq), 32'h0);
    end
    // Overload at a delta of 76 and 77, then converter results
    wr(6'h15, 8'h80, OK);
    sm(8'hC3, 8'h00, 7'h55);
    sm(8'hC3, 8'h4C, 7'h55);
    rd(6'h1E, 8'h00, OK);
    sm(8'hC3, 8'h99, 7'h55);
    rd(6'h1E, 8'h08, OK);
    rd(6'h1A, 8'hC3, OK);
    rd(6'h1B, 8'h98, OK);
    rd(6'h1C, 8'hAA, OK);
    // Over-current at both limits
    wr(6'h12, 8'h02, OK);
    wr(6'h05, 8'h04, OK);
    wr(6'h15, 8'h05, OK);
    for (k = 0; k < 2; k++) begin
      wr(6'h20, k ? 8'h04 : 8'h00, OK);
      sm(8'h00, 8'h00, othr[k]);
      rd(6'h1E, 8'h00, OK);
      sm(8'h00, 8'h00, othr[k] + 7'h01);
      chk({onHookRequest, irq}, 32'h3);
      rd(6'h1E, 8'h10, OK);
      sm(8'h00, 8'h00, 7'h00);
      rd(6'h03, 8'h04, OK);
      rd(6'h03, 8'h00, OK);
    end
    // Under-voltage with and without line power and master enable
    supplyUnderVoltage <= 1'b1;
    linePoweredMode <= 1'b1;
    tk(4);
    chk({wideBandwidthForce, barrierPowerSwitch}, 32'h3);
    rd(6'h1E, 8'h40, OK);
    linePoweredMode <= 1'b0;
    tk(4);
    chk({wideBandwidthForce, barrierPowerSwitch}, 32'h2);
    wr(6'h12, 8'h00, OK);
    tk(3);
    chk({wideBandwidthForce, irq}, 32'h1);
    rd(6'h1E, 8'h00, OK);
    rd(6'h03, 8'h04, OK);
    chk(32'(irq), 32'h0);
    // Over-voltage at both limits, then gated by nominal mode
    supplyUnderVoltage <= 1'b0;
    wr(6'h12, 8'h02, OK);
    wr(6'h20, 8'h03, OK);
    wr(6'h15, 8'h02, OK);
    for (k = 0; k < 2; k++) begin
      wr(6'h13, {5'h0, k[0], 2'h0}, OK);
      sm({1'b0, vthr[k]}, 8'h00, 7'h00);
      rd(6'h1E, 8'h00, OK);
      sm({1'b1, ~(vthr[k] + 7'h01)}, 8'h00, 7'h00);
      chk(32'(onHookRequest), 32'h1);
      rd(6'h1E, 8'h20, OK);
    end
    wr(6'h20, 8'h01, OK);
    sm(8'h7F, 8'h00, 7'h00);
    rd(6'h1E, 8'h00, OK);
    // Audio path gain for each caller-ID and boost setting
    rxAudio <= 16'h0064;
    ringAudio <= 16'h0007;
    for (k = 0; k < 4; k++) begin
      wr(6'h15, {3'h0, k[0], 4'h0}, OK);
      wr(6'h14, {4'h0, k[1], 3'h0}, OK);
      audioValid <= 1'b1;
      @(posedge ref_clk);
      audioValid <= 1'b0;
      @(posedge ref_clk);
      chk(32'(pcmTransmitValid), 32'h1);
      chk(32'(pcmTransmitOut), gain[k]);
    end
    tally_and_finish();
  end
endmodule
